// ---- pte_defines.vh ----
// Constants for the transmit encoder: register map, fields, codes, timing
`ifndef PTE_DEFINES_VH
`define PTE_DEFINES_VH

`define PTE_ADDR_W        8
`define PTE_ADDR_MODE     8'h00
`define PTE_ADDR_TXST     8'h04
`define PTE_ADDR_INTC     8'h08
`define PTE_ADDR_STAT     8'h0c
`define PTE_RESP_OKAY     2'h0
`define PTE_RESP_SLVERR   2'h2

`define PTE_MODE_RESET    8'h08
`define PTE_MODE_NRZ_BIT  6
`define PTE_MODE_SE_BIT   3
`define PTE_MODE_LB_MSB   2
`define PTE_MODE_LB_LSB   1
`define PTE_TXST_RESET    8'h00
`define PTE_TXST_PCE_BIT  6
`define PTE_TXST_MD_MSB   2
`define PTE_TXST_MD_LSB   0
`define PTE_INTC_PERR_BIT 0
`define PTE_STAT_FLT_LSB  0
`define PTE_STAT_EXT_BIT  2
`define PTE_STAT_CNT_LSB  4

`define PTE_TXM_ACTIVE    3'h0
`define PTE_TXM_IDLE      3'h1
`define PTE_TXM_MASTER    3'h2
`define PTE_TXM_HALT      3'h3
`define PTE_TXM_QUIET     3'h4
`define PTE_TXM_OFF       3'h5

`define PTE_LB_INT        2'h1
`define PTE_LB_EXT        2'h2

`define PTE_SYM_I         5'h1f
`define PTE_SYM_H         5'h04
`define PTE_SYM_Q         5'h00
`define PTE_SYM_J         5'h18
`define PTE_SYM_K         5'h11
`define PTE_SYM_T         5'h0d
`define PTE_SYM_R         5'h07
`define PTE_SYM_S         5'h19
`define PTE_SYM_N         5'h1e
`define PTE_SYM_V         5'h01

`define PTE_CN_JK         4'hd
`define PTE_CN_T0         4'h4
`define PTE_CN_T1         4'h5
`define PTE_CN_R          4'h6
`define PTE_CN_S          4'h7
`define PTE_CN_Q          4'h2
`define PTE_CN_I          4'hf
`define PTE_CN_H          4'h1
`define PTE_CN_N          4'h0

`define PTE_BYTE_RESET    10'h3ff
`define PTE_BIT_LAST      4'h9
`define PTE_BIT_PRELOAD   4'h8
`define PTE_PRE_TARGET    4'h7
`define PTE_CNT_MAX       4'hf

`endif

// ---- pte_transmit_encoder.v ----
// Transmit path: parity check, 4B/5B, repeat filter, smoother, line coder
//
// Behaviour
// - Take one 10-bit byte per byte time
// - Bit 9 parity, bit 8 control, two nibbles
// - Odd parity checked; even count is error
// - Parity check enable bit gates errors
// - Parity error sets flag, feeds filter violation
// - Control flag selects data or control codes
// - Data nibbles map through 4B/5B table
// - Control codes give JK, T and R
// - Violations replaced by Halt pairs then Idle
// - Repeat violation sends two Halt pairs
// - Idle pair forces Idle until JK
// - JK enters Repeat state unless a non-active mode forces Idle
// - Repeat state: R/S before T is violation
// - One Idle added ahead of a JK after fewer than seven Idles, unless already extended
// - Target seven Idles; extend or delete
// - Idle pair counts; JK stops count
// - Route serial bits by loopback mode
// - Mode bit picks NRZI or NRZ
// - Line state generator overrides inactive modes
`timescale 1ns/1ps
`default_nettype none
`include "pte_defines.vh"

module pte_transmit_encoder (
	input  wire                  aclk,
	input  wire                  aresetn,
	input  wire                  ce,
	input  wire [`PTE_ADDR_W-1:0] s_axi_awaddr,
	input  wire                  s_axi_awvalid,
	output reg                   s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output reg                   s_axi_wready,
	output reg  [1:0]            s_axi_bresp,
	output reg                   s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [`PTE_ADDR_W-1:0] s_axi_araddr,
	input  wire                  s_axi_arvalid,
	output reg                   s_axi_arready,
	output reg  [31:0]           s_axi_rdata,
	output reg  [1:0]            s_axi_rresp,
	output reg                   s_axi_rvalid,
	input  wire                  s_axi_rready,
	input  wire [9:0]            tx_byte,
	output reg                   byte_take,
	output reg                   pmd_tx_data,
	output reg                   pmd_tx_enable,
	output reg                   int_loop_data,
	output reg                   ext_loop_data
);

	localparam [1:0] FLT_IDLE   = 2'h0;
	localparam [1:0] FLT_REPEAT = 2'h1;
	localparam [1:0] FLT_HALT   = 2'h2;
	localparam [1:0] FLT_END    = 2'h3;

	localparam [9:0] PAIR_II = {`PTE_SYM_I, `PTE_SYM_I};
	localparam [9:0] PAIR_HH = {`PTE_SYM_H, `PTE_SYM_H};
	localparam [9:0] PAIR_HQ = {`PTE_SYM_H, `PTE_SYM_Q};
	localparam [9:0] PAIR_QQ = {`PTE_SYM_Q, `PTE_SYM_Q};
	localparam [9:0] PAIR_JK = {`PTE_SYM_J, `PTE_SYM_K};

	reg [7:0]             mode_reg;
	reg [7:0]             current_transmit_state_reg;
	reg                   data_parity_error_flag;
	reg [9:0]             data_reg;
	reg [9:0]             shift_reg;
	reg [3:0]             bit_cnt_reg;
	reg [1:0]             flt_reg;
	reg                   sm_ext_reg;
	reg [9:0]             sm_hold_reg;
	reg [3:0]             pre_cnt_reg;
	reg                   nrzi_reg;
	reg                   aw_full_reg;
	reg                   w_full_reg;
	reg [`PTE_ADDR_W-1:0] aw_addr_reg;
	reg [31:0]            w_data_reg;
	reg [3:0]             w_strb_reg;

	wire       parity_check_enable = current_transmit_state_reg[`PTE_TXST_PCE_BIT];
	wire [2:0] transmit_mode_field =
		current_transmit_state_reg[`PTE_TXST_MD_MSB:`PTE_TXST_MD_LSB];
	wire       nrz_transmit_select = mode_reg[`PTE_MODE_NRZ_BIT];
	wire       smooth_en = mode_reg[`PTE_MODE_SE_BIT];
	wire [1:0] loop_sel = mode_reg[`PTE_MODE_LB_MSB:`PTE_MODE_LB_LSB];
	wire       tick = (bit_cnt_reg == `PTE_BIT_LAST);
	wire       force_idle = (transmit_mode_field != `PTE_TXM_ACTIVE);

	// Data nibble to 5B code
	function [4:0] pte_data5;
		input [3:0] n;
		begin
			case (n)
				4'h0: pte_data5 = 5'h1e;
				4'h1: pte_data5 = 5'h09;
				4'h2: pte_data5 = 5'h14;
				4'h3: pte_data5 = 5'h15;
				4'h4: pte_data5 = 5'h0a;
				4'h5: pte_data5 = 5'h0b;
				4'h6: pte_data5 = 5'h0e;
				4'h7: pte_data5 = 5'h0f;
				4'h8: pte_data5 = 5'h12;
				4'h9: pte_data5 = 5'h13;
				4'ha: pte_data5 = 5'h16;
				4'hb: pte_data5 = 5'h17;
				4'hc: pte_data5 = 5'h1a;
				4'hd: pte_data5 = 5'h1b;
				4'he: pte_data5 = 5'h1c;
				default: pte_data5 = 5'h1d;
			endcase
		end
	endfunction

	// Control nibble to {violation, 5B code}; unknown codes become V
	function [5:0] pte_ctrl5;
		input [3:0] n;
		begin
			case (n)
				`PTE_CN_T0: pte_ctrl5 = {1'b0, `PTE_SYM_T};
				`PTE_CN_T1: pte_ctrl5 = {1'b0, `PTE_SYM_T};
				`PTE_CN_R:  pte_ctrl5 = {1'b0, `PTE_SYM_R};
				`PTE_CN_S:  pte_ctrl5 = {1'b0, `PTE_SYM_S};
				`PTE_CN_Q:  pte_ctrl5 = {1'b0, `PTE_SYM_Q};
				`PTE_CN_I:  pte_ctrl5 = {1'b0, `PTE_SYM_I};
				`PTE_CN_H:  pte_ctrl5 = {1'b0, `PTE_SYM_H};
				`PTE_CN_N:  pte_ctrl5 = {1'b0, `PTE_SYM_N};
				default:    pte_ctrl5 = {1'b1, `PTE_SYM_V};
			endcase
		end
	endfunction

	// Frame status symbol test, used for both halves of a pair
	function pte_is_rs;
		input [4:0] c;
		begin
			pte_is_rs = (c == `PTE_SYM_R) || (c == `PTE_SYM_S);
		end
	endfunction

	// odd parity over parity and data bits
	wire parity_err = parity_check_enable &&
		~(^{data_reg[9], data_reg[7:0]}); // gated by enable

	// field split; control flag selects table
	reg [9:0] enc_code;
	reg       enc_viol;
	reg       hi_dat;
	reg       lo_dat;
	reg [5:0] hi6;
	reg [5:0] lo6;
	always @* begin
		hi6 = pte_ctrl5(data_reg[7:4]);
		lo6 = pte_ctrl5(data_reg[3:0]);
		if (!data_reg[8]) begin
			// data table; upper nibble in the high half
			enc_code = {pte_data5(data_reg[7:4]), pte_data5(data_reg[3:0])};
			enc_viol = 1'b0;
			hi_dat = 1'b1;
			lo_dat = 1'b1;
		end else if (data_reg[7:4] == `PTE_CN_JK) begin
			enc_code = PAIR_JK;
			enc_viol = 1'b0;
			hi_dat = 1'b0;
			lo_dat = 1'b0;
		end else begin
			// T, R and the other control codes
			enc_code = {hi6[4:0], lo6[4:0]};
			enc_viol = hi6[5] | lo6[5];
			hi_dat = (data_reg[7:4] == `PTE_CN_N);
			lo_dat = (data_reg[3:0] == `PTE_CN_N);
		end
	end

	// Repeat filter; JK and Idle tests come first so they win in every state
	wire bad = enc_viol | parity_err; // parity error acts as a violation
	wire t_hi = (enc_code[9:5] == `PTE_SYM_T);
	wire t_lo = (enc_code[4:0] == `PTE_SYM_T);
	wire w_hi = t_hi | pte_is_rs(enc_code[9:5]);
	wire w_lo = t_lo | pte_is_rs(enc_code[4:0]);
	reg [1:0] flt_next;
	reg [9:0] flt_out;
	always @* begin
		flt_next = flt_reg;
		flt_out = enc_code;
		if (force_idle) begin
			flt_next = FLT_IDLE;
			flt_out = PAIR_II;
		end else if (enc_code == PAIR_JK) begin
			flt_next = FLT_REPEAT;
		end else if (enc_code[9:5] == `PTE_SYM_I) begin
			flt_next = FLT_IDLE;
			flt_out = PAIR_II;
		end else begin
			case (flt_reg)
				FLT_REPEAT: begin
					// violation sends first Halt pair; R/S before T
					if (bad || !(hi_dat || t_hi) || (hi_dat && !(lo_dat || t_lo))) begin
						flt_next = FLT_HALT;
						flt_out = PAIR_HH;
					end else if (t_hi || t_lo) begin
						// data then T closes the frame
						flt_next = FLT_END;
					end
				end
				FLT_END: begin
					// anything but R, S or T after the end is cut off
					if (bad || !(w_hi && w_lo)) begin
						flt_next = FLT_HALT;
						flt_out = PAIR_HH;
					end
				end
				FLT_HALT: begin
					flt_next = FLT_IDLE;
					flt_out = PAIR_HH;
				end
				default: begin
					flt_out = PAIR_II;
				end
			endcase
		end
	end

	// Smoother; one byte of hold lets an Idle be inserted, a later long
	// preamble gives that byte back
	reg       sm_ext_next;
	reg [9:0] sm_hold_next;
	reg [9:0] sm_out;
	always @* begin
		sm_ext_next = sm_ext_reg;
		sm_hold_next = sm_hold_reg;
		sm_out = flt_out;
		if (sm_ext_reg) begin
			sm_out = sm_hold_reg;
			// delete one Idle from a preamble over seven
			if (flt_out == PAIR_II && sm_hold_reg == PAIR_II &&
			    (pre_cnt_reg >= `PTE_PRE_TARGET || !smooth_en)) begin
				sm_ext_next = 1'b0;
			end else begin
				sm_hold_next = flt_out;
			end
		end else if (smooth_en && flt_out == PAIR_JK && pre_cnt_reg < `PTE_PRE_TARGET) begin
			// Extend, one Idle inserted ahead of the JK
			sm_out = PAIR_II;
			sm_hold_next = flt_out;
			sm_ext_next = 1'b1;
		end
	end

	// line state generator overrides inactive modes
	reg [9:0] tx_pair;
	always @* begin
		case (transmit_mode_field)
			`PTE_TXM_ACTIVE: tx_pair = sm_out;
			`PTE_TXM_IDLE:   tx_pair = PAIR_II;
			`PTE_TXM_MASTER: tx_pair = PAIR_HQ;
			`PTE_TXM_HALT:   tx_pair = PAIR_HH;
			default:        tx_pair = PAIR_QQ; // Quiet, Off and reserved
		endcase
	end

	// NRZI toggles on one; NRZ passes the bit
	wire line_bit = nrz_transmit_select ? shift_reg[9] : (nrzi_reg ^ shift_reg[9]);

	// Byte pipeline and serializer, one bit per clock
	always @(posedge aclk) begin
		if (!aresetn) begin
			data_reg <= `PTE_BYTE_RESET;
			shift_reg <= PAIR_II;
			bit_cnt_reg <= 4'h0;
			flt_reg <= FLT_IDLE;
			sm_ext_reg <= 1'b0;
			sm_hold_reg <= PAIR_II;
			pre_cnt_reg <= 4'h0;
			nrzi_reg <= 1'b0;
			byte_take <= 1'b0;
			pmd_tx_data <= 1'b0;
			pmd_tx_enable <= 1'b0;
			int_loop_data <= 1'b0;
			ext_loop_data <= 1'b0;
		end else if (ce) begin
			bit_cnt_reg <= tick ? 4'h0 : bit_cnt_reg + 4'h1;
			byte_take <= (bit_cnt_reg == `PTE_BIT_PRELOAD);
			if (tick) begin
				// upstream byte taken once per byte time
				data_reg <= tx_byte;
				shift_reg <= tx_pair;
				flt_reg <= flt_next;
				sm_ext_reg <= sm_ext_next;
				sm_hold_reg <= sm_hold_next;
				// Idle pairs count, JK stops and clears
				if (sm_out == PAIR_JK)
					pre_cnt_reg <= 4'h0;
				else if (sm_out == PAIR_II && pre_cnt_reg != `PTE_CNT_MAX)
					pre_cnt_reg <= pre_cnt_reg + 4'h1;
			end else begin
				shift_reg <= {shift_reg[8:0], 1'b0};
			end
			nrzi_reg <= line_bit;
			// route serial stream by loopback mode
			pmd_tx_data <= (loop_sel != `PTE_LB_INT && loop_sel != `PTE_LB_EXT) & line_bit;
			int_loop_data <= (loop_sel == `PTE_LB_INT) & line_bit;
			ext_loop_data <= (loop_sel == `PTE_LB_EXT) & line_bit;
			pmd_tx_enable <= (transmit_mode_field != `PTE_TXM_OFF);
		end
	end

	// Register read decode, also flags unmapped addresses
	reg [31:0] rd_data;
	reg        rd_err;
	always @* begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		case (s_axi_araddr)
			`PTE_ADDR_MODE: rd_data[7:0] = mode_reg;
			`PTE_ADDR_TXST: rd_data[7:0] = current_transmit_state_reg;
			`PTE_ADDR_INTC: rd_data[`PTE_INTC_PERR_BIT] = data_parity_error_flag;
			`PTE_ADDR_STAT: begin
				rd_data[`PTE_STAT_FLT_LSB +: 2] = flt_reg;
				rd_data[`PTE_STAT_EXT_BIT] = sm_ext_reg;
				rd_data[`PTE_STAT_CNT_LSB +: 4] = pre_cnt_reg;
			end
			default: rd_err = 1'b1;
		endcase
	end

	wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire wr_low = do_write && w_strb_reg[0];
	wire wr_map = (aw_addr_reg == `PTE_ADDR_MODE) || (aw_addr_reg == `PTE_ADDR_TXST) ||
		(aw_addr_reg == `PTE_ADDR_INTC) || (aw_addr_reg == `PTE_ADDR_STAT);
	wire flag_clr = wr_low && aw_addr_reg == `PTE_ADDR_INTC && w_data_reg[`PTE_INTC_PERR_BIT];
	wire perr_set = tick && parity_err;

	// AXI4-Lite slave; address and data are caught independently
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PTE_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PTE_RESP_OKAY;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= {`PTE_ADDR_W{1'b0}};
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			mode_reg <= `PTE_MODE_RESET;
			current_transmit_state_reg <= `PTE_TXST_RESET;
			data_parity_error_flag <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `PTE_RESP_OKAY : `PTE_RESP_SLVERR;
				if (wr_low && aw_addr_reg == `PTE_ADDR_MODE)
					mode_reg <= w_data_reg[7:0];
				if (wr_low && aw_addr_reg == `PTE_ADDR_TXST)
					current_transmit_state_reg <= w_data_reg[7:0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// parity error flag, set wins over write-one clear
			data_parity_error_flag <= perr_set | (data_parity_error_flag & ~flag_clr);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `PTE_RESP_SLVERR : `PTE_RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ---- pte_transmit_encoder_assertions.sv ----
// Port-level checker for the transmit encoder, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module pte_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        byte_take,
	input wire logic        pmd_tx_data,
	input wire logic        int_loop_data,
	input wire logic        ext_loop_data
);
	logic [3:0] gap_reg;
	logic       seen_reg;
	// A frozen clock enable stalls everything, so nothing is judged then
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	// Enabled edges since the last byte strobe; first strobe only arms it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_reg  <= 4'h0;
			seen_reg <= 1'b0;
		end else if (ce) begin
			gap_reg  <= byte_take ? 4'h0 : gap_reg + 4'h1;
			seen_reg <= seen_reg | byte_take;
		end
	end
	a_byte_spacing: assert property (seen_reg |-> (byte_take == (gap_reg == 4'h9)))
		else $error("byte strobe not every ten cycles");
	a_one_route: assert property ($onehot0({pmd_tx_data, int_loop_data, ext_loop_data}))
		else $error("serial bit on more than one route");
	a_aw_hold: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready back before response");
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_b_release: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not released");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not next cycle");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
		else $error("read channel not released");
endmodule
bind pte_transmit_encoder pte_checker u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .byte_take, .pmd_tx_data,
	.int_loop_data, .ext_loop_data);
`default_nettype wire

// ---- pte_transmit_encoder_bench.sv ----
// Self-checking bench for the transmit encoder
`timescale 1ns/1ps
`default_nettype none
`include "pte_defines.vh"
module pte_transmit_encoder_bench;
	logic        aclk, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [9:0]  tx_byte;
	logic        byte_take, pmd_tx_data, pmd_tx_enable, int_loop_data, ext_loop_data;
	logic        ce = 1'b1;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [9:0]  eq[$];
	// 5-bit data codes, nibble F down to 0
	logic [79:0] code5 = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
		5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
	int          err_total = 0, num_checks = 0;
	pte_transmit_encoder DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_byte,
		.byte_take, .pmd_tx_data, .pmd_tx_enable, .int_loop_data, .ext_loop_data);
	pte_upstream_model pm (.aclk, .byte_take, .pmd_tx_data, .tx_byte);
	function automatic logic [9:0] mk(input logic c, input logic [7:0] d);
		mk = {~^d, c, d};
	endfunction
	function automatic logic [9:0] pr(input logic [7:0] d);
		pr = {code5[d[7:4]*5 +: 5], code5[d[3:0]*5 +: 5]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tx(input logic [9:0] b);
		pm.tx_q.push_back(b);
	endtask
	// Response ready goes up with the request; only the watchdog ends a wait
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Let the queued bytes pass, then compare the pairs after the first JK
	task automatic run_frame();
		int j;
		pm.rx_q.delete();
		j = -1;
		repeat (300) @(posedge aclk);
		for (int i = pm.rx_q.size() - 1; i >= 0; i--)
			if (pm.rx_q[i] === 10'h311) j = i;
		chk(j >= 0, 1);
		foreach (eq[k]) chk(pm.rx_q[j + 1 + k], eq[k]);
		eq.delete();
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axr(`PTE_ADDR_MODE, d, r);
		chk(d, 32'h08);
		axr(`PTE_ADDR_TXST, d, r);
		chk(d, 32'h00);
		axr(`PTE_ADDR_STAT, d, r);
		chk(d[1:0], 2'h0);
		axr(8'h10, d, r);
		chk(r, `PTE_RESP_SLVERR);
		axw(8'h10, 32'h0, `PTE_RESP_SLVERR);
		// Status is read-only; a write without byte lane 0 changes nothing
		axw(`PTE_ADDR_STAT, 32'hff, `PTE_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		axw(`PTE_ADDR_MODE, 32'h0, `PTE_RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		axr(`PTE_ADDR_MODE, d, r);
		chk(d, 32'h08);
	endtask
	task automatic t_encode();
		axw(`PTE_ADDR_MODE, 32'h48, `PTE_RESP_OKAY);
		tx(mk(1, 8'hdd));
		for (int k = 0; k < 8; k++) begin
			tx(mk(0, 8'(8'h01 + 8'h22 * k)));
			eq.push_back(pr(8'(8'h01 + 8'h22 * k)));
		end
		tx(mk(1, 8'h47));
		eq.push_back(10'h1b9);
		eq.push_back(10'h3ff);
		run_frame();
	endtask
	// Five idles between frames must come out as six
	task automatic t_smooth();
		tx(mk(1, 8'hdd));
		tx(mk(0, 8'h12));
		tx(mk(1, 8'h46));
		repeat (5) tx(10'h3ff);
		tx(mk(1, 8'hdd));
		tx(mk(1, 8'h46));
		eq = '{pr(8'h12), 10'h1a7, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h311};
		run_frame();
	endtask
	// Code violation, R before T, bad parity checked, bad parity unchecked
	task automatic t_viol();
		logic [9:0]  bad [4];
		logic [31:0] d;
		logic [1:0]  r;
		bad = '{mk(1, 8'h33), mk(1, 8'h66), mk(0, 8'h5a) ^ 10'h200, mk(0, 8'h5a) ^ 10'h200};
		for (int k = 0; k < 4; k++) begin
			axw(`PTE_ADDR_TXST, (k == 3) ? 32'h0 : 32'h40, `PTE_RESP_OKAY);
			tx(mk(1, 8'hdd));
			tx(mk(0, 8'h12));
			tx(bad[k]);
			tx(mk(0, 8'h34));
			tx(mk(0, 8'h56));
			tx(mk(1, 8'h46));
			if (k == 3)
				eq = '{pr(8'h12), pr(8'h5a), pr(8'h34), pr(8'h56), 10'h1a7};
			else
				eq = '{pr(8'h12), 10'h084, 10'h084, 10'h3ff, 10'h3ff};
			run_frame();
			axr(`PTE_ADDR_INTC, d, r);
			chk(d, (k == 2));
			axw(`PTE_ADDR_INTC, 32'h1, `PTE_RESP_OKAY);
		end
	endtask
	task automatic t_modes();
		logic [9:0] m [8];
		m = '{10'h0, 10'h3ff, 10'h080, 10'h084, 10'h0, 10'h0, 10'h0, 10'h0};
		for (int k = 1; k < 8; k++) begin
			axw(`PTE_ADDR_TXST, k, `PTE_RESP_OKAY);
			repeat (60) @(posedge aclk);
			chk(pm.rx_q[$], m[k]);
			chk(pmd_tx_enable, k != 5);
		end
	endtask
	// Idles in NRZI toggle every bit; loopback moves the bits off the medium
	task automatic t_line();
		axw(`PTE_ADDR_TXST, 32'h1, `PTE_RESP_OKAY);
		axw(`PTE_ADDR_MODE, 32'h08, `PTE_RESP_OKAY);
		repeat (60) @(posedge aclk);
		chk(pm.rx_q[$] === 10'h155 || pm.rx_q[$] === 10'h2aa, 1);
		for (int lb = 1; lb < 3; lb++) begin
			axw(`PTE_ADDR_MODE, 32'h48 | (lb << 1), `PTE_RESP_OKAY);
			repeat (40) @(posedge aclk);
			chk({pmd_tx_data, int_loop_data, ext_loop_data}, (lb == 1) ? 3'h2 : 3'h1);
		end
	endtask
	// Clock enable low must freeze the byte strobe and every serial output
	task automatic t_freeze();
		logic [4:0] s;
		ce <= 1'b0;
		@(posedge aclk);
		s = {byte_take, pmd_tx_data, pmd_tx_enable, int_loop_data, ext_loop_data};
		repeat (12) begin
			@(posedge aclk);
			chk({byte_take, pmd_tx_data, pmd_tx_enable, int_loop_data, ext_loop_data}, s);
		end
		ce <= 1'b1;
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_encode();
		t_smooth();
		t_viol();
		t_modes();
		t_line();
		t_freeze();
		end_sim();
	end
	// Whole run is a few thousand cycles; this cuts off a hang
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire

// ---- pte_upstream_model.sv ----
// Upstream byte source and serial pair capture for the transmit encoder
`timescale 1ns/1ps
`default_nettype none
module pte_upstream_model (
	input  wire logic       aclk,
	input  wire logic       byte_take,
	input  wire logic       pmd_tx_data,
	output var  logic [9:0] tx_byte
);
	logic [9:0] tx_q[$];
	logic [9:0] rx_q[$];
	logic [8:0] sh_reg = 9'h000;
	logic       take_d = 1'b0;
	initial tx_byte = 10'h3ff;
	// byte field layout
	// Next byte follows each take; the idle control byte fills gaps so the
	// source never leaves stale data on the bus
	// A pair is captured one edge after the take, when its tenth bit stands
	always @(posedge aclk) begin
		take_d <= byte_take;
		if (byte_take)
			tx_byte <= (tx_q.size() > 0) ? tx_q.pop_front() : 10'h3ff;
		if (take_d)
			rx_q.push_back({sh_reg, pmd_tx_data});
		sh_reg <= {sh_reg[7:0], pmd_tx_data};
	end
endmodule
`default_nettype wire
